// file: hdl/ltw_pkg.sv
// Package: register map, field positions and timing constants of the timer
package ltw_pkg;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_CAPT = 12'h004;
  localparam logic [11:0] ADDR_HALT = 12'h008;
  localparam int CNT_W = 13;
  localparam logic [12:0] CNT_WRAP = 13'h1F39;
  localparam logic [12:0] CNT_ZERO = 13'h0000;
  localparam int CAP_LSB = 5;
  localparam int BIT_CIE = 7;
  localparam int BIT_CEF = 6;
  localparam int BIT_TBD = 5;
  localparam int BIT_TIE = 4;
  localparam int BIT_TEF = 3;
  localparam int BIT_WRF = 2;
  localparam int BIT_WEN = 1;
  localparam int BIT_WDL = 0;
  localparam int BIT_HALT = 0;
  localparam int HALT_RESUME_CYC = 64;
  localparam logic [6:0] RESUME_W = 7'h40;
  localparam logic [31:0] SLV_ZERO = 32'h00000000;
endpackage : ltw_pkg

// file: hdl/ltw_capture.sv
// Edge-triggered capture of the upper counter bits with a sticky flag
`timescale 1ns/100ps
module ltw_capture (
  input wire logic clk,
  input wire logic reset,
  input wire logic capture_input_pin,
  input wire logic [7:0] count_hi,
  input wire logic rd_clear,
  output logic [7:0] capture_value,
  output logic capture_event_flag
);
  logic pin_reg;
  logic [7:0] cap_reg;
  logic flag_reg;
  wire edge_seen = capture_input_pin ^ pin_reg;
  wire take = edge_seen & ~flag_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      pin_reg <= 1'b0;
      cap_reg <= 8'h00;
      flag_reg <= 1'b0;
    end else begin
      pin_reg <= capture_input_pin;
      if (take) begin
        cap_reg <= count_hi;
      end
      if (take) begin
        flag_reg <= 1'b1;
      end else if (rd_clear) begin
        flag_reg <= 1'b0;
      end
    end
  end
  assign capture_value = cap_reg;
  assign capture_event_flag = flag_reg;

  chk_capture_hold: assert property (
    @(posedge clk) disable iff (reset)
    flag_reg |=> $stable(cap_reg))
    else $error("capture changed while flag set");
  cov_capture: cover property (@(posedge clk) disable iff (reset) take);
endmodule : ltw_capture

// file: hdl/ltw_watchdog.sv
// Watchdog period counter built on the timebase counter overflow ticks
`timescale 1ns/100ps
module ltw_watchdog (
  input wire logic clk,
  input wire logic reset,
  input wire logic running,
  input wire logic tick,
  input wire logic active,
  input wire logic force_req,
  output logic period_end,
  output logic expire
);
  // Two overflow ticks make one watchdog period, counted from reset
  logic [1:0] ticks_reg;
  logic elapsed_reg;
  wire end_now = running & tick & ticks_reg[0];

  always_ff @(posedge clk) begin
    if (reset) begin
      ticks_reg <= 2'h0;
      elapsed_reg <= 1'b0;
    end else begin
      if (running && tick) begin
        ticks_reg <= ticks_reg[0] ? 2'h0 : 2'h1;
      end
      // Only a period missed while disabled is remembered for later
      if (end_now && !active) begin
        elapsed_reg <= 1'b1;
      end else if (active) begin
        elapsed_reg <= 1'b0;
      end
    end
  end
  assign period_end = end_now;
  assign expire = (active & (end_now | elapsed_reg)) | force_req;
endmodule : ltw_watchdog

// file: hdl/ltw_timer.sv
// Lite timebase, watchdog and capture timer with APB register slave
`timescale 1ns/100ps
module ltw_timer #(
  parameter bit HW_WATCHDOG = 1'b0,
  parameter bit RESET_ON_HALT = 1'b0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic lvd_reset,
  input wire logic wdg_caused_reset,
  input wire logic halt_req,
  input wire logic ext_wakeup,
  input wire logic capture_input_pin,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic timebase_irq,
  output logic capture_irq,
  output logic watchdog_reset_req
);
  ////////////////////////////////////////////////////////////////////////
  logic [12:0] count_reg;
  logic half_reg;
  logic tbd_reg, tie_reg, tef_reg, cie_reg, wen_reg, wdl_reg, wrf_reg;
  logic halted_reg;
  logic [6:0] resume_reg;
  logic [31:0] prdata_reg;
  logic tb_irq_reg, cap_irq_reg, wdr_reg;
  logic pslverr_reg;
  logic [7:0] cap_val;
  logic cap_flag;
  logic wd_end, wd_expire;

  wire access = psel & penable;
  wire wr = access & pwrite;
  wire rd = access & ~pwrite;
  wire sel_ctrl = paddr == ltw_pkg::ADDR_CTRL;
  wire sel_capt = paddr == ltw_pkg::ADDR_CAPT;
  wire sel_halt = paddr == ltw_pkg::ADDR_HALT;
  wire mapped = sel_ctrl | sel_capt | sel_halt;
  wire rd_ctrl = rd & sel_ctrl;
  wire rd_capt = rd & sel_capt;
  wire wr_ctrl = wr & sel_ctrl;
  wire running = ~halted_reg;
  wire wrap = running & (count_reg == ltw_pkg::CNT_WRAP);
  wire tb_event = wrap & (tbd_reg ? half_reg : 1'b1);
  wire wd_active = (HW_WATCHDOG | wen_reg) & (resume_reg == 7'h00);
  wire wd_armed = HW_WATCHDOG | wen_reg;
  wire wd_refreshed = wdl_reg;
  wire force_reset = wd_armed & wrf_reg & ~wdr_reg;
  wire wd_fire = (wd_expire & ~wd_refreshed) | force_reset;
  wire [7:0] ctrl_view = {cie_reg, cap_flag, tbd_reg, tie_reg, tef_reg,
                          wrf_reg, wen_reg, wdl_reg};
  wire [31:0] rd_mux = sel_ctrl ? {24'h000000, ctrl_view} :
                       sel_capt ? {24'h000000, cap_val} :
                       sel_halt ? {31'h00000000, halted_reg} :
                       ltw_pkg::SLV_ZERO;

  ////////////////////////////////////////////////////////////////////////
  // Free-running counter, frozen during halt
  always_ff @(posedge clk) begin
    if (reset) begin
      count_reg <= ltw_pkg::CNT_ZERO;
      half_reg <= 1'b0;
    end else if (wrap) begin
      count_reg <= ltw_pkg::CNT_ZERO;
      half_reg <= ~half_reg;
    end else if (running) begin
      count_reg <= count_reg + 13'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Halt state and watchdog resume delay after wake-up
  always_ff @(posedge clk) begin
    if (reset) begin
      halted_reg <= 1'b0;
      resume_reg <= 7'h00;
    end else if (halted_reg && ext_wakeup) begin
      halted_reg <= 1'b0;
      resume_reg <= ltw_pkg::RESUME_W;
    end else begin
      if (halt_req && !RESET_ON_HALT) begin
        halted_reg <= 1'b1;
      end
      if (resume_reg != 7'h00) begin
        resume_reg <= resume_reg - 7'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control/status bits
  always_ff @(posedge clk) begin
    if (reset) begin
      cie_reg <= 1'b0;
      tbd_reg <= 1'b0;
      tie_reg <= 1'b0;
      wen_reg <= 1'b0;
      wdl_reg <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        cie_reg <= pwdata[ltw_pkg::BIT_CIE];
        tbd_reg <= pwdata[ltw_pkg::BIT_TBD];
        tie_reg <= pwdata[ltw_pkg::BIT_TIE];
        wen_reg <= pwdata[ltw_pkg::BIT_WEN];
      end
      if (wr_ctrl && pwdata[ltw_pkg::BIT_WDL]) begin
        wdl_reg <= 1'b1;
      end else if (wd_end) begin
        wdl_reg <= 1'b0;
      end
    end
  end

  // Timebase flag: set wins over read-clear
  always_ff @(posedge clk) begin
    if (reset) begin
      tef_reg <= 1'b0;
    end else if (tb_event) begin
      tef_reg <= 1'b1;
    end else if (rd_ctrl) begin
      tef_reg <= 1'b0;
    end
  end

  // Watchdog reset flag survives ordinary resets; only LVD or a control register read clears it
  always_ff @(posedge clk) begin
    if (lvd_reset) begin
      wrf_reg <= 1'b0;
    end else if (reset) begin
      wrf_reg <= wrf_reg | wdg_caused_reset;
    end else if (wr_ctrl && pwdata[ltw_pkg::BIT_WRF]) begin
      wrf_reg <= 1'b1;
    end else if (rd_ctrl) begin
      wrf_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs and APB read data
  always_ff @(posedge clk) begin
    if (reset) begin
      prdata_reg <= ltw_pkg::SLV_ZERO;
      tb_irq_reg <= 1'b0;
      cap_irq_reg <= 1'b0;
      wdr_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      // Error is decided in setup so it stands through the access cycle
      pslverr_reg <= psel & ~penable & ~mapped;
      if (psel && !penable && !pwrite) begin
        prdata_reg <= rd_mux;
      end
      tb_irq_reg <= tef_reg & tie_reg;
      cap_irq_reg <= cap_flag & cie_reg;
      wdr_reg <= wd_fire;
    end
  end

  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = pslverr_reg;
  assign timebase_irq = tb_irq_reg;
  assign capture_irq = cap_irq_reg;
  assign watchdog_reset_req = wdr_reg;

  ltw_watchdog u_wdg (
    .clk(clk),
    .reset(reset),
    .running(running),
    .tick(wrap),
    .active(wd_active),
    .force_req(1'b0),
    .period_end(wd_end),
    .expire(wd_expire)
  );

  ltw_capture u_cap (
    .clk(clk),
    .reset(reset),
    .capture_input_pin(capture_input_pin),
    .count_hi(count_reg[ltw_pkg::CNT_W-1:ltw_pkg::CAP_LSB]),
    .rd_clear(rd_capt),
    .capture_value(cap_val),
    .capture_event_flag(cap_flag)
  );

  ////////////////////////////////////////////////////////////////////////
  // Counter
  chk_counter_wrap: assert property (
    @(posedge clk) disable iff (reset)
    (count_reg == ltw_pkg::CNT_WRAP && running) |=>
      count_reg == ltw_pkg::CNT_ZERO)
    else $error("counter did not wrap at end value");
  chk_count_range: assert property (
    @(posedge clk) disable iff (reset)
    count_reg <= ltw_pkg::CNT_WRAP)
    else $error("counter beyond end value");
  chk_count_step: assert property (
    @(posedge clk) disable iff (reset)
    (running && !wrap) |=> count_reg == $past(count_reg) + 13'h0001)
    else $error("counter did not step by one");
  chk_count_clear: assert property (
    @(posedge clk)
    reset |=> count_reg == ltw_pkg::CNT_ZERO)
    else $error("counter not cleared by reset");
  chk_halt_freeze: assert property (
    @(posedge clk) disable iff (reset)
    (halted_reg && !ext_wakeup) |=> $stable(count_reg))
    else $error("counter moved in halt");
  ////////////////////////////////////////////////////////////////////////
  // Timebase
  chk_tb_single: assert property (
    @(posedge clk) disable iff (reset)
    (wrap && !tbd_reg) |-> tb_event)
    else $error("timebase event missing on wrap");
  chk_tb_double: assert property (
    @(posedge clk) disable iff (reset)
    (wrap && tbd_reg && !half_reg) |-> !tb_event)
    else $error("timebase event on skipped wrap");
  chk_tbflag_set: assert property (
    @(posedge clk) disable iff (reset)
    tb_event |=> tef_reg)
    else $error("timebase flag not set");
  chk_tbflag_idle: assert property (
    @(posedge clk) disable iff (reset)
    (!tef_reg && !tb_event) |=> !tef_reg)
    else $error("timebase flag set without event");
  chk_tbflag_clear: assert property (
    @(posedge clk) disable iff (reset)
    (rd_ctrl && !tb_event) |=> !tef_reg)
    else $error("timebase flag not cleared by read");
  chk_tbflag_keep: assert property (
    @(posedge clk) disable iff (reset)
    (tef_reg && !rd_ctrl) |=> tef_reg)
    else $error("timebase flag lost without read");
  chk_tb_irq: assert property (
    @(posedge clk) disable iff (reset)
    (tef_reg && !tie_reg) |=> !timebase_irq)
    else $error("timebase irq while disabled");
  chk_tb_irq_on: assert property (
    @(posedge clk) disable iff (reset)
    (tef_reg && tie_reg) |=> timebase_irq)
    else $error("timebase irq missing");
  chk_irq_reset: assert property (
    @(posedge clk)
    reset |=> !timebase_irq)
    else $error("timebase irq after reset");
  ////////////////////////////////////////////////////////////////////////
  // Capture
  chk_cap_irq: assert property (
    @(posedge clk) disable iff (reset)
    (cap_flag && cie_reg) |=> capture_irq)
    else $error("capture irq missing");
  chk_cap_irq_off: assert property (
    @(posedge clk) disable iff (reset)
    (cap_flag && !cie_reg) |=> !capture_irq)
    else $error("capture irq while disabled");
  chk_cap_clear: assert property (
    @(posedge clk) disable iff (reset)
    (rd_capt && cap_flag) |=> !cap_flag)
    else $error("capture flag not cleared by read");
  ////////////////////////////////////////////////////////////////////////
  // Watchdog
  chk_wdg_timeout: assert property (
    @(posedge clk) disable iff (reset)
    (wd_end && wd_active && !wdl_reg) |=> watchdog_reset_req)
    else $error("watchdog expiry gave no reset");
  chk_wdg_off: assert property (
    @(posedge clk) disable iff (reset)
    !wd_armed |=> !watchdog_reset_req)
    else $error("reset while watchdog disabled");
  chk_delay_refresh: assert property (
    @(posedge clk) disable iff (reset)
    (wd_end && wdl_reg && !force_reset) |=> !watchdog_reset_req)
    else $error("reset despite delay bit");
  chk_delay_set: assert property (
    @(posedge clk) disable iff (reset)
    (wr_ctrl && pwdata[ltw_pkg::BIT_WDL]) |=> wdl_reg)
    else $error("delay bit not set by write");
  chk_delay_clear: assert property (
    @(posedge clk) disable iff (reset)
    (wd_end && !(wr_ctrl && pwdata[ltw_pkg::BIT_WDL])) |=> !wdl_reg)
    else $error("delay bit not cleared at period end");
  chk_force_reset: assert property (
    @(posedge clk) disable iff (reset)
    (wen_reg && wrf_reg && !wdr_reg) |=> watchdog_reset_req)
    else $error("forced reset missing");
  chk_wrf_write: assert property (
    @(posedge clk) disable iff (reset)
    (wr_ctrl && pwdata[ltw_pkg::BIT_WRF] && !lvd_reset) |=> wrf_reg)
    else $error("reset flag not set by write");
  chk_wrf_read: assert property (
    @(posedge clk) disable iff (reset)
    (rd_ctrl && !lvd_reset) |=> !wrf_reg)
    else $error("reset flag not cleared by read");
  chk_wrf_cause: assert property (
    @(posedge clk)
    (reset && wdg_caused_reset && !lvd_reset) |=> wrf_reg)
    else $error("reset flag not set by watchdog reset");
  chk_wrf_keep: assert property (
    @(posedge clk)
    (reset && wrf_reg && !lvd_reset) |=> wrf_reg)
    else $error("reset flag lost on ordinary reset");
  chk_wrf_lvd: assert property (
    @(posedge clk)
    lvd_reset |=> !wrf_reg)
    else $error("reset flag kept through low-voltage reset");
  chk_wen_reset: assert property (
    @(posedge clk)
    reset |=> !wen_reg)
    else $error("watchdog enabled after reset");
  ////////////////////////////////////////////////////////////////////////
  // Halt and wake-up
  chk_halt_enter: assert property (
    @(posedge clk) disable iff (reset)
    (halt_req && !RESET_ON_HALT && !halted_reg) |=> halted_reg)
    else $error("halt not entered");
  chk_halt_hold: assert property (
    @(posedge clk) disable iff (reset)
    (halted_reg && !ext_wakeup) |=> halted_reg)
    else $error("halt left without wake-up");
  chk_wake_leave: assert property (
    @(posedge clk) disable iff (reset)
    (halted_reg && ext_wakeup) |=> !halted_reg)
    else $error("halt not left on wake-up");
  chk_resume_wait: assert property (
    @(posedge clk) disable iff (reset)
    (halted_reg && ext_wakeup) |=> resume_reg == ltw_pkg::RESUME_W)
    else $error("resume delay not loaded");
  chk_resume_block: assert property (
    @(posedge clk) disable iff (reset)
    (resume_reg != 7'h00) |-> !wd_active)
    else $error("watchdog active during resume delay");
  chk_resume_count: assert property (
    @(posedge clk) disable iff (reset)
    (resume_reg != 7'h00 && !(halted_reg && ext_wakeup)) |=>
      resume_reg == $past(resume_reg) - 7'h01)
    else $error("resume delay did not count down");
  ////////////////////////////////////////////////////////////////////////
  // Register read path, then coverage points
  chk_rd_sample: assert property (
    @(posedge clk) disable iff (reset)
    (psel && !penable && !pwrite) |=> prdata == $past(rd_mux))
    else $error("read data not loaded in setup");
  cov_tb: cover property (@(posedge clk) disable iff (reset) tb_event);
  cov_tb_double: cover property (@(posedge clk) disable iff (reset)
    tb_event && tbd_reg);
  cov_wdr: cover property (@(posedge clk) disable iff (reset) wd_fire);
  cov_wake: cover property (@(posedge clk) disable iff (reset)
    halted_reg && ext_wakeup);
endmodule : ltw_timer

// file: dv/ltw_pin_model.sv
// Far-side capture source: toggles the capture pin on request
`timescale 1ns/100ps
module ltw_pin_model (
  input wire logic clk,
  input wire logic flip,
  output logic capture_input_pin
);
  initial capture_input_pin = 1'b0;
  always @(posedge clk) begin
    if (flip) begin
      capture_input_pin <= ~capture_input_pin;
    end
  end
endmodule : ltw_pin_model

// file: dv/tb.sv
// Testbench of the lite timer: APB access, timebase, capture, watchdog
`timescale 1ns/100ps
module tb;
  logic clk, reset, lvd, wcause, halt_req, wake, psel, penable, pwrite;
  logic pready, pslverr, tb_irq, cap_irq, wdg_req, pin, flip, perr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int err_count, cmp_count, cnt, t, e, c;
  // Timebase counter period: it runs from zero up to its end value
  localparam int PER = int'(ltw_pkg::CNT_WRAP) + 1;
  ltw_timer ltw_timer_inst (.clk(clk), .reset(reset), .lvd_reset(lvd),
    .wdg_caused_reset(wcause), .halt_req(halt_req), .ext_wakeup(wake),
    .capture_input_pin(pin), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timebase_irq(tb_irq),
    .capture_irq(cap_irq), .watchdog_reset_req(wdg_req));
  ltw_pin_model ltw_pin_model_inst (.clk(clk), .flip(flip),
    .capture_input_pin(pin));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Bench copy of the hidden counter, cycles since reset release
  always @(posedge clk) cnt <= reset ? 0 : cnt + 1;
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x) begin
      err_count++;
      $display("BAD %s exp %h got %h", n, x, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rst(input logic w, input logic l);
    @(posedge clk);
    reset <= 1'b1;
    wcause <= w;
    lvd <= l;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    wcause <= 1'b0;
    lvd <= 1'b0;
  endtask : rst
  task automatic wait_to(input int n);
    while (cnt < n) @(posedge clk);
  endtask : wait_to
  task automatic wait_req;
    c = 0;
    while (wdg_req !== 1'b1 && c < 40) begin
      @(posedge clk);
      c++;
    end
    chk("wdg_req", {31'h0, wdg_req}, 32'h1);
  endtask : wait_req
  task automatic toggle;
    while ((cnt % PER) % 32 != 12) @(posedge clk);
    e = (cnt % PER) >> 5;
    @(posedge clk);
    flip <= 1'b1;
    @(posedge clk);
    flip <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : toggle
  task automatic stop_test;
    if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {reset, lvd, wcause, halt_req, wake, psel, penable, pwrite, flip} = '0;
    reset = 1'b1;
    paddr = '0;
    pwdata = '0;
    t = $urandom(49);
    rst(1'b0, 1'b1);
    apb(1'b0, ltw_pkg::ADDR_CTRL, 0);
    chk("ctrl", rd, 32'h0);
    apb(1'b0, 12'h00C, 0);
    chk("slverr", {31'h0, perr}, 32'h1);
    apb(1'b1, ltw_pkg::ADDR_CTRL, 32'h90);
    wait_to(7900);
    apb(1'b0, ltw_pkg::ADDR_CTRL, 0);
    chk("ctrl", rd, 32'h90);
    wait_to(8100);
    chk("tb_irq", {31'h0, tb_irq}, 32'h1);
    apb(1'b0, ltw_pkg::ADDR_CTRL, 0);
    chk("ctrl", rd, 32'h98);
    apb(1'b0, ltw_pkg::ADDR_CTRL, 0);
    chk("ctrl", rd, 32'h90);
    wait_to(8200 + ($urandom % 50) * 32);
    toggle();
    t = e;
    chk("cap_irq", {31'h0, cap_irq}, 32'h1);
    toggle();
    apb(1'b1, ltw_pkg::ADDR_CAPT, 32'hFF);
    apb(1'b0, ltw_pkg::ADDR_CAPT, 0);
    chk("capt", rd, 32'(t));
    apb(1'b0, ltw_pkg::ADDR_CTRL, 0);
    chk("ctrl", rd, 32'h90);
    apb(1'b1, ltw_pkg::ADDR_CTRL, 32'h93);
    wait_to(16100);
    apb(1'b0, ltw_pkg::ADDR_CTRL, 0);
    chk("ctrl", rd, 32'h9A);
    wait_to(4 * PER - 20);
    chk("wdg_req", {31'h0, wdg_req}, 32'h0);
    wait_req();
    rst(1'b1, 1'b0);
    apb(1'b0, ltw_pkg::ADDR_CTRL, 0);
    chk("ctrl", rd, 32'h4);
    apb(1'b0, ltw_pkg::ADDR_CTRL, 0);
    chk("ctrl", rd, 32'h0);
    apb(1'b1, ltw_pkg::ADDR_CTRL, 32'h2);
    apb(1'b1, ltw_pkg::ADDR_CTRL, 32'h6);
    wait_req();
    rst(1'b1, 1'b0);
    apb(1'b1, ltw_pkg::ADDR_CTRL, 32'h2);
    wait_req();
    rst(1'b0, 1'b1);
    apb(1'b1, ltw_pkg::ADDR_CTRL, 32'h20);
    wait_to(8100);
    apb(1'b0, ltw_pkg::ADDR_CTRL, 0);
    chk("ctrl", rd, 32'h20);
    wait_to(16100);
    apb(1'b0, ltw_pkg::ADDR_CTRL, 0);
    chk("ctrl", rd, 32'h28);
    apb(1'b1, ltw_pkg::ADDR_CTRL, 32'h2);
    wait_req();
    rst(1'b0, 1'b0);
    @(posedge clk);
    halt_req <= 1'b1;
    @(posedge clk);
    halt_req <= 1'b0;
    apb(1'b0, ltw_pkg::ADDR_HALT, 0);
    chk("halt", rd, 32'h1);
    repeat (9000) @(posedge clk);
    apb(1'b0, ltw_pkg::ADDR_CTRL, 0);
    chk("ctrl", rd, 32'h0);
    @(posedge clk);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    apb(1'b0, ltw_pkg::ADDR_HALT, 0);
    chk("halt", rd, 32'h0);
    stop_test();
  end
  initial begin
    #2500000;
    err_count++;
    stop_test();
  end
endmodule : tb
